// ### prls_sequencer.sv
// per-axis positioning sequencer with begin/end repeat loop control
`timescale 1ns/10ps

// How it works
// - entries between begin-repeat and end-repeat run as often as the count says
// - begin-repeat with count zero raises loop setting error code 545
// - begin-repeat with no end-repeat: no error, entries run once
// - nested pairs: only the innermost pair repeats, outer runs once
// - end-repeat with repeats left jumps back to entry after begin-repeat
// - count used up: leave loop at end-repeat, go to next entry
// - operation pattern of begin and end entries ignored; neither halts sequence
// - motion fields of loop entries ignored; end entry auxiliary code ignored
// - end-repeat met before any begin-repeat is ignored
// - loop may nest with the separate special-start counted repeat
// - block runs from continuous entries up to a positioning-complete entry
module prls_sequencer #(
    parameter int DEPTH = 600,
    parameter int AW = 10
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // avalon-mm slave
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata_q,
    output logic avs_waitrequest_q,
    // motion executor
    output prls_pkg::prls_motion_t motion_q,
    input wire logic motion_done,
    // interrupt
    output logic irq_q
);

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_READ,
        ST_EXEC,
        ST_MOVE,
        ST_NEXT
    } prls_state_t;

    // =====================================================================
    // declarations
    prls_state_t state_q;
    logic [AW-1:0] ptr_q;
    logic [AW-1:0] ret_q;
    logic [15:0] count_q;
    logic loop_active_q;
    logic loop_seen_q;
    logic [15:0] error_q;
    logic [2:0] int_status_q;
    logic [2:0] int_mask_q;
    logic [AW-1:0] tbl_addr_q;
    logic ev_done;
    logic ev_error;
    logic ev_loop;
    logic bus_req;
    logic bus_commit;
    logic wr_commit;
    logic start_req;
    logic tbl_wr;
    prls_pkg::prls_entry_t entry;
    logic is_begin;
    logic is_end;
    logic last_entry;

    function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] p);
        next_ptr = p + AW'(1);
    endfunction

    function automatic logic [31:0] zext(input logic [15:0] v);
        zext = {16'h0000, v};
    endfunction

    // =====================================================================
    // avalon-mm handshake: answer one cycle after the request is seen
    assign bus_req = avs_read | avs_write;
    assign bus_commit = bus_req & ~avs_waitrequest_q;
    assign wr_commit = avs_write & ~avs_waitrequest_q;
    assign start_req = wr_commit && (avs_address == prls_pkg::REG_CTRL)
        && avs_writedata[prls_pkg::CTRL_START_BIT];
    assign tbl_wr = wr_commit && (avs_address == prls_pkg::REG_TBL_DATA);

    always_ff @(posedge clk) begin
        if (!nrst) begin
            avs_waitrequest_q <= 1'b1;
        end else if (bus_commit) begin
            avs_waitrequest_q <= 1'b1;
        end else if (bus_req) begin
            avs_waitrequest_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            avs_readdata_q <= 32'h0000_0000;
        end else if (avs_read && avs_waitrequest_q) begin
            unique case (avs_address)
                prls_pkg::REG_STATUS: begin
                    avs_readdata_q <= {{(16 - AW){1'b0}}, ptr_q, 13'h0000,
                        loop_active_q, (error_q != prls_pkg::ERR_NONE),
                        (state_q != ST_IDLE)};
                end
                prls_pkg::REG_ERROR: avs_readdata_q <= zext(error_q);
                prls_pkg::REG_INT_STATUS: avs_readdata_q <= {29'h0, int_status_q};
                prls_pkg::REG_INT_MASK: avs_readdata_q <= {29'h0, int_mask_q};
                prls_pkg::REG_TBL_ADDR: avs_readdata_q <= {{(32 - AW){1'b0}}, tbl_addr_q};
                prls_pkg::REG_LOOP: begin
                    avs_readdata_q <= {{(16 - AW){1'b0}}, ret_q, count_q};
                end
                default: avs_readdata_q <= 32'h0000_0000;
            endcase
        end
    end

    // =====================================================================
    // table write path, address auto-increments
    always_ff @(posedge clk) begin
        if (!nrst) begin
            tbl_addr_q <= '0;
        end else if (wr_commit && (avs_address == prls_pkg::REG_TBL_ADDR)) begin
            tbl_addr_q <= avs_writedata[AW-1:0];
        end else if (tbl_wr) begin
            tbl_addr_q <= next_ptr(tbl_addr_q);
        end
    end

    prls_table_mem #(
        .DEPTH(DEPTH),
        .AW(AW)
    ) u_table (
        .clk(clk),
        .wr_en(tbl_wr),
        .wr_addr(tbl_addr_q),
        .wr_data(prls_pkg::prls_entry_t'(avs_writedata)),
        .rd_addr(ptr_q),
        .rd_data_q(entry)
    );

    // =====================================================================
    // entry decode; of a loop entry only control system and auxiliary code are looked at
    assign is_begin = entry.control_system_field == prls_pkg::CS_REPEAT_BEGIN;
    assign is_end = entry.control_system_field == prls_pkg::CS_REPEAT_END;
    assign last_entry = (32'(ptr_q) >= DEPTH - 1);

    // =====================================================================
    // sequencer state
    always_ff @(posedge clk) begin
        if (!nrst) begin
            state_q <= ST_IDLE;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (start_req) begin
                        state_q <= ST_READ;
                    end
                end
                ST_READ: state_q <= ST_EXEC;
                ST_EXEC: begin
                    if (is_begin && entry.auxiliary_code_field == 16'h0000) begin
                        state_q <= ST_IDLE;
                    end else if (is_begin || is_end) begin
                        state_q <= last_entry ? ST_IDLE : ST_NEXT;
                    end else begin
                        state_q <= ST_MOVE;
                    end
                end
                ST_MOVE: begin
                    if (motion_done) begin
                        if (entry.operation_pattern_field == prls_pkg::OP_COMPLETE
                            || last_entry) begin
                            state_q <= ST_IDLE;
                        end else begin
                            state_q <= ST_NEXT;
                        end
                    end
                end
                ST_NEXT: state_q <= ST_READ;
            endcase
        end
    end

    // entry pointer
    always_ff @(posedge clk) begin
        if (!nrst) begin
            ptr_q <= '0;
        end else if (state_q == ST_IDLE && start_req) begin
            ptr_q <= avs_writedata[prls_pkg::CTRL_ENTRY_LSB +: AW];
        end else if (state_q == ST_EXEC && is_end && loop_active_q
            && count_q != 16'h0001) begin
            ptr_q <= ret_q;
        end else if (state_q == ST_EXEC && (is_begin || is_end) && !last_entry) begin
            ptr_q <= next_ptr(ptr_q);
        end else if (state_q == ST_MOVE && motion_done && !last_entry
            && entry.operation_pattern_field != prls_pkg::OP_COMPLETE) begin
            ptr_q <= next_ptr(ptr_q);
        end
    end

    // loop registers, independent of any outer special-start repeat
    always_ff @(posedge clk) begin
        if (!nrst) begin
            count_q <= 16'h0000;
            ret_q <= '0;
            loop_active_q <= 1'b0;
        end else if (state_q == ST_IDLE && start_req) begin
            loop_active_q <= 1'b0;
        end else if (state_q == ST_EXEC && is_begin
            && entry.auxiliary_code_field != 16'h0000) begin
            // a later begin overwrites the return point, so outer runs once
            count_q <= entry.auxiliary_code_field;
            ret_q <= next_ptr(ptr_q);
            loop_active_q <= 1'b1;
        end else if (state_q == ST_EXEC && is_end && loop_active_q) begin
            count_q <= count_q - 16'h0001;
            if (count_q == 16'h0001) begin
                loop_active_q <= 1'b0;
            end
        end else if (state_q == ST_MOVE && motion_done
            && entry.operation_pattern_field == prls_pkg::OP_COMPLETE) begin
            loop_active_q <= 1'b0;
        end
    end

    // remembers that a begin-repeat ran since start
    always_ff @(posedge clk) begin
        if (!nrst) begin
            loop_seen_q <= 1'b0;
        end else if (state_q == ST_IDLE && start_req) begin
            loop_seen_q <= 1'b0;
        end else if (state_q == ST_EXEC && is_begin) begin
            loop_seen_q <= 1'b1;
        end
    end

    // error code
    always_ff @(posedge clk) begin
        if (!nrst) begin
            error_q <= prls_pkg::ERR_NONE;
        end else if (state_q == ST_EXEC && is_begin
            && entry.auxiliary_code_field == 16'h0000) begin
            error_q <= prls_pkg::ERR_LOOP_SETTING;
        end else if (state_q == ST_IDLE && start_req) begin
            error_q <= prls_pkg::ERR_NONE;
        end
    end

    // =====================================================================
    // motion request: one-cycle pulse per motion entry
    always_ff @(posedge clk) begin
        if (!nrst) begin
            motion_q <= '0;
        end else begin
            motion_q.valid <= (state_q == ST_EXEC) && !is_begin && !is_end;
            // entry number holds between requests
            if (state_q == ST_EXEC && !is_begin && !is_end) begin
                motion_q.entry <= ptr_q;
            end
        end
    end

    // =====================================================================
    // interrupts: sticky, write one to clear, set wins
    assign ev_error = state_q == ST_EXEC && is_begin && entry.auxiliary_code_field == 16'h0000;
    assign ev_done = (state_q == ST_MOVE && motion_done
        && (entry.operation_pattern_field == prls_pkg::OP_COMPLETE || last_entry))
        || (state_q == ST_EXEC && (is_begin || is_end) && last_entry && !ev_error);
    assign ev_loop = state_q == ST_EXEC && is_end && loop_active_q && loop_seen_q
        && count_q == 16'h0001;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            int_status_q <= 3'h0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                if ((i == prls_pkg::INT_DONE_BIT && ev_done)
                    || (i == prls_pkg::INT_ERROR_BIT && ev_error)
                    || (i == prls_pkg::INT_LOOP_BIT && ev_loop)) begin
                    int_status_q[i] <= 1'b1;
                end else if (wr_commit && avs_address == prls_pkg::REG_INT_STATUS
                    && avs_writedata[i]) begin
                    int_status_q[i] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            int_mask_q <= prls_pkg::INT_MASK_RESET;
        end else if (wr_commit && avs_address == prls_pkg::REG_INT_MASK) begin
            int_mask_q <= avs_writedata[2:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(int_status_q & int_mask_q);
        end
    end

endmodule

// ### prls_pkg.sv
// shared constants, encodings and carrier types of the repeat-loop sequencer
package prls_pkg;

    // =====================================================================
    // register map (byte addresses)
    localparam logic [4:0] REG_CTRL = 5'h00;
    localparam logic [4:0] REG_STATUS = 5'h04;
    localparam logic [4:0] REG_ERROR = 5'h08;
    localparam logic [4:0] REG_INT_STATUS = 5'h0c;
    localparam logic [4:0] REG_INT_MASK = 5'h10;
    localparam logic [4:0] REG_TBL_ADDR = 5'h14;
    localparam logic [4:0] REG_TBL_DATA = 5'h18;
    localparam logic [4:0] REG_LOOP = 5'h1c;

    // =====================================================================
    // field positions
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_ENTRY_LSB = 16;
    localparam int INT_DONE_BIT = 0;
    localparam int INT_ERROR_BIT = 1;
    localparam int INT_LOOP_BIT = 2;
    localparam int STATUS_PTR_LSB = 16;

    // =====================================================================
    // reset values and codes
    localparam logic [2:0] INT_MASK_RESET = 3'h0;
    localparam logic [15:0] ERR_NONE = 16'h0000;
    localparam logic [15:0] ERR_LOOP_SETTING = 16'h0221;

    // control system codes
    localparam logic [7:0] CS_REPEAT_BEGIN = 8'h1e;
    localparam logic [7:0] CS_REPEAT_END = 8'h1f;

    // operation pattern codes
    localparam logic [1:0] OP_COMPLETE = 2'h0;
    localparam logic [1:0] OP_CONTINUOUS = 2'h1;
    localparam logic [1:0] OP_CONT_PATH = 2'h3;

    // =====================================================================
    // one positioning entry as stored in the table
    typedef struct packed {
        logic [15:0] auxiliary_code_field;
        logic [7:0] control_system_field;
        logic [5:0] spare;
        logic [1:0] operation_pattern_field;
    } prls_entry_t;

    // motion request towards the motion executor
    typedef struct packed {
        logic valid;
        logic [9:0] entry;
    } prls_motion_t;

endpackage

// ### prls_table_mem.sv
// positioning entry table: one write port, registered read port
`timescale 1ns/10ps
module prls_table_mem #(
    parameter int DEPTH = 600,
    parameter int AW = 10
) (
    // clock
    input wire logic clk,
    // write port
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire prls_pkg::prls_entry_t wr_data,
    // read port
    input wire logic [AW-1:0] rd_addr,
    output prls_pkg::prls_entry_t rd_data_q
);

    prls_pkg::prls_entry_t mem [DEPTH];

    always_ff @(posedge clk) begin
        if (wr_en && (32'(wr_addr) < DEPTH)) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clk) begin
        if (32'(rd_addr) < DEPTH) begin
            rd_data_q <= mem[rd_addr];
        end else begin
            rd_data_q <= '0;
        end
    end

endmodule

// ### prls_sequencer_monitor.sv
// port-level concurrent checks for the repeat-loop sequencer
`timescale 1ns/10ps
module prls_sequencer_monitor (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // avalon-mm slave
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata_q,
    input wire logic avs_waitrequest_q,
    // motion and interrupt
    input wire prls_pkg::prls_motion_t motion_q,
    input wire logic motion_done,
    input wire logic irq_q
);
    // ==========================================================
    // bus, motion and interrupt properties
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    chk_wait_answer: assert property (
        (avs_read || avs_write) && avs_waitrequest_q |=> !avs_waitrequest_q)
        else $error("waitrequest not lowered one cycle after request");
    chk_wait_single: assert property (!avs_waitrequest_q |=> avs_waitrequest_q)
        else $error("waitrequest low longer than one cycle");
    chk_wait_idle: assert property (!(avs_read || avs_write) |=> avs_waitrequest_q)
        else $error("waitrequest low without request");
    chk_unmapped_zero: assert property (
        avs_read && !avs_waitrequest_q && avs_address[1:0] != 2'h0 |-> avs_readdata_q == 32'h0)
        else $error("unmapped read not zero");
    chk_read_hold: assert property (
        $changed(avs_readdata_q) |-> $past(avs_read && avs_waitrequest_q))
        else $error("read data changed without read");
    chk_motion_gap: assert property (motion_q.valid |=> !motion_q.valid [*4])
        else $error("motion requests closer than allowed");
    chk_entry_hold: assert property ($changed(motion_q.entry) |-> motion_q.valid)
        else $error("motion entry changed without request");
    chk_irq_masked: assert property (
        avs_write && !avs_waitrequest_q && avs_address == prls_pkg::REG_INT_MASK
        && avs_writedata[2:0] == 3'h0 |-> ##2 !irq_q)
        else $error("interrupt stays high with all sources masked");
endmodule

bind prls_sequencer prls_sequencer_monitor u_prls_sequencer_monitor (.clk(clk), .nrst(nrst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata_q(avs_readdata_q),
    .avs_waitrequest_q(avs_waitrequest_q), .motion_q(motion_q),
    .motion_done(motion_done), .irq_q(irq_q));

// ### prls_sequencer_tb.sv
// self-checking testbench for the repeat-loop sequencer
`timescale 1ns/10ps
module prls_sequencer_tb;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata_q;
    logic avs_waitrequest_q;
    prls_pkg::prls_motion_t motion_q;
    logic motion_done = 1'b0;
    logic irq_q;
    logic [31:0] seed = 32'h37;
    logic [31:0] rd;
    logic [2:0] mask;
    logic [9:0] exp_q[$];
    logic [31:0] w[$];
    int n_errors = 0;
    int num_checks = 0;
    int n;

    prls_sequencer u_prls_sequencer (.clk(clk), .nrst(nrst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata_q(avs_readdata_q), .avs_waitrequest_q(avs_waitrequest_q),
        .motion_q(motion_q), .motion_done(motion_done), .irq_q(irq_q));

    initial begin
        forever #50 clk = ~clk;
    end

    // ==========================================================
    // helpers
    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function logic [31:0] ent(input logic [15:0] aux, input logic [7:0] cs, input logic [1:0] op);
        logic [31:0] r;
        r = rnd();
        return {aux, cs, r[5:0], op};
    endfunction

    task check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        do @(posedge clk); while (avs_waitrequest_q !== 1'b0);
        rd = avs_readdata_q;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task load(input logic [9:0] a);
        bus(1'b1, prls_pkg::REG_TBL_ADDR, {22'h0, a});
        foreach (w[i]) bus(1'b1, prls_pkg::REG_TBL_DATA, w[i]);
    endtask

    task run(input logic [9:0] s, input logic [15:0] err, input logic [2:0] ints);
        bus(1'b1, prls_pkg::REG_CTRL, {6'h0, s, 15'h0, 1'b1});
        for (int i = 0; i < 400; i++) begin
            bus(1'b0, prls_pkg::REG_STATUS, 32'h0);
            if (rd[0] === 1'b0) break;
        end
        check(rd[0], 1'b0);
        bus(1'b0, prls_pkg::REG_ERROR, 32'h0);
        check(rd[15:0], err);
        bus(1'b0, prls_pkg::REG_INT_STATUS, 32'h0);
        check(rd[2:0], ints);
        check(irq_q, |(ints & mask));
        bus(1'b1, prls_pkg::REG_INT_STATUS, 32'h7);
        repeat (2) @(posedge clk);
        check(irq_q, 1'b0);
        check(exp_q.size(), 0);
    endtask

    task set_mask(input logic [2:0] m);
        mask = m;
        bus(1'b1, prls_pkg::REG_INT_MASK, {29'h0, m});
        bus(1'b0, prls_pkg::REG_INT_MASK, 32'h0);
        check(rd[2:0], m);
    endtask

    task end_sim();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // ==========================================================
    // motion executor side: compares each request with the oldest note
    initial begin
        logic [9:0] e;
        forever begin
            @(posedge clk);
            if (motion_q.valid === 1'b1) begin
                e = exp_q.size() ? exp_q.pop_front() : 10'h3ff;
                check(motion_q.entry, e);
                repeat (1 + rnd() % 3) @(posedge clk);
                motion_done <= 1'b1;
                @(posedge clk);
                motion_done <= 1'b0;
            end
        end
    end

    initial begin
        repeat (60000) @(posedge clk);
        n_errors++;
        end_sim();
    end

    // ==========================================================
    // main sequence
    initial begin
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        bus(1'b0, prls_pkg::REG_ERROR, 32'h0);
        check(rd[15:0], prls_pkg::ERR_NONE);
        bus(1'b0, prls_pkg::REG_INT_STATUS, 32'h0);
        check(rd[2:0], 3'h0);
        bus(1'b0, 5'h01, 32'h0);
        check(rd, 32'h0);
        bus(1'b0, prls_pkg::REG_INT_MASK, 32'h0);
        check(rd[2:0], prls_pkg::INT_MASK_RESET);
        set_mask(3'h1);
        // counted loop with complete patterns on the loop entries
        n = 1 + rnd() % 3;
        w = '{ent(16'h1, 8'h01, prls_pkg::OP_CONTINUOUS),
            ent(n[15:0], prls_pkg::CS_REPEAT_BEGIN, prls_pkg::OP_COMPLETE),
            ent(16'h0, 8'h01, prls_pkg::OP_CONT_PATH), ent(16'h0, 8'h01, prls_pkg::OP_CONTINUOUS),
            ent(16'h9, prls_pkg::CS_REPEAT_END, prls_pkg::OP_COMPLETE),
            ent(16'h0, 8'h01, prls_pkg::OP_COMPLETE)};
        load(10'd1);
        exp_q = {10'd1};
        repeat (n) exp_q = {exp_q, 10'd3, 10'd4};
        exp_q.push_back(10'd6);
        run(10'd1, prls_pkg::ERR_NONE, 3'h5);
        bus(1'b0, prls_pkg::REG_LOOP, 32'h0);
        check(rd, {6'h0, 10'h3, 16'h0000});
        // zero repeat count
        set_mask(3'h2);
        w = '{ent(16'h0, prls_pkg::CS_REPEAT_BEGIN, prls_pkg::OP_CONTINUOUS)};
        load(10'd10);
        run(10'd10, prls_pkg::ERR_LOOP_SETTING, 3'h2);
        bus(1'b0, prls_pkg::REG_STATUS, 32'h0);
        check(rd[2:0], 3'h2);
        set_mask(3'h0);
        // begin without end
        w = '{ent(16'h0, 8'h01, prls_pkg::OP_CONTINUOUS),
            ent(16'h3, prls_pkg::CS_REPEAT_BEGIN, prls_pkg::OP_CONTINUOUS),
            ent(16'h0, 8'h01, prls_pkg::OP_COMPLETE)};
        load(10'd20);
        exp_q = {10'd20, 10'd22};
        run(10'd20, prls_pkg::ERR_NONE, 3'h1);
        // nested pairs: only the inner one repeats
        w = '{ent(16'h2, prls_pkg::CS_REPEAT_BEGIN, prls_pkg::OP_CONTINUOUS),
            ent(16'h0, 8'h01, prls_pkg::OP_CONTINUOUS),
            ent(16'h2, prls_pkg::CS_REPEAT_BEGIN, prls_pkg::OP_CONTINUOUS),
            ent(16'h0, 8'h01, prls_pkg::OP_CONTINUOUS),
            ent(16'h0, prls_pkg::CS_REPEAT_END, prls_pkg::OP_CONTINUOUS),
            ent(16'h0, prls_pkg::CS_REPEAT_END, prls_pkg::OP_COMPLETE),
            ent(16'h0, 8'h01, prls_pkg::OP_COMPLETE)};
        load(10'd30);
        exp_q = {10'd31, 10'd33, 10'd33, 10'd36};
        run(10'd30, prls_pkg::ERR_NONE, 3'h5);
        // stray end with a count in its auxiliary field
        w = '{ent(16'h5, prls_pkg::CS_REPEAT_END, prls_pkg::OP_COMPLETE),
            ent(16'h0, 8'h01, prls_pkg::OP_COMPLETE)};
        load(10'd40);
        exp_q = {10'd41};
        run(10'd40, prls_pkg::ERR_NONE, 3'h1);
        bus(1'b0, prls_pkg::REG_TBL_ADDR, 32'h0);
        check(rd, 32'h0000_002a);
        // end-repeat in the last table entry ends the run
        w = '{ent(16'h0, prls_pkg::CS_REPEAT_END, prls_pkg::OP_CONTINUOUS)};
        load(10'h257);
        run(10'h257, prls_pkg::ERR_NONE, 3'h1);
        end_sim();
    end
endmodule
